// *** rtl/dmmao_pkg.sv ***
// Constants and types for the converter result-output stage
package dmmao_pkg;
   // ----------------------------------------------------------------
   // Register offsets (byte addresses, one 32-bit word each)
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_GAIN_CONTROL = 8'h00;
   localparam logic [7:0] OFS_CONVERTER_SETUP = 8'h04;
   localparam logic [7:0] OFS_FINE_RESULT = 8'h08;
   localparam logic [7:0] OFS_FAST_RESULT = 8'h0c;
   localparam logic [7:0] OFS_STATUS = 8'h10;

   // ----------------------------------------------------------------
   // Field positions and reset values
   // ----------------------------------------------------------------
   localparam int CONVERTER_ENABLE_BIT = 7;
   localparam int CYS_LSB = 4;
   localparam int FAST_TAP_LSB = 2;
   localparam int FINE_TAP_LSB = 0;
   localparam int STAT_FINE_NEW_BIT = 0;
   localparam int STAT_FAST_NEW_BIT = 1;
   localparam logic [7:0] GAIN_CONTROL_RESET = 8'h00;
   localparam logic [7:0] CONVERTER_SETUP_RESET = 8'h00;

   // ----------------------------------------------------------------
   // Offset-cycle modes
   // ----------------------------------------------------------------
   localparam logic [1:0] CYS_OFFSET_READ = 2'h0;
   localparam logic [1:0] CYS_CANCELLED = 2'h1;
   localparam logic [1:0] CYS_RESERVED = 2'h2;
   localparam logic [1:0] CYS_RAW = 2'h3;

   // ----------------------------------------------------------------
   // Decimator tap counts as log2 (tap select 00 -> 2048 / 32)
   // ----------------------------------------------------------------
   localparam logic [4:0] FINE_LOG_BASE = 5'h0b;
   localparam logic [4:0] FAST_LOG_BASE = 5'h05;
   // Left shift that places 1.0 at bit 21 (fine) or bit 13 (fast)
   localparam logic [4:0] FINE_SHIFT_BASE = 5'h0a;
   localparam logic [4:0] FAST_SHIFT_BASE = 5'h08;
   localparam int FINE_W = 24;
   localparam int FAST_W = 16;

   // ----------------------------------------------------------------
   // Resolution models and saturation thresholds on bits 21:18
   // ----------------------------------------------------------------
   localparam logic [1:0] MODEL_5K = 2'h0;
   localparam logic [1:0] MODEL_20K = 2'h1;
   localparam logic [1:0] MODEL_50K = 2'h2;
   localparam logic [3:0] SAT_THR_WIDE = 4'ha;
   localparam logic [3:0] SAT_THR_20K = 4'h5;
   localparam logic [3:0] SAT_FIELD = 4'hf;

   typedef enum logic {CHOP_DIRECT, CHOP_SWAPPED} dmmao_chop_t;
endpackage

// *** rtl/dmmao_decim.sv ***
// Integrate-and-dump decimator for the one-bit modulator stream
`timescale 1ns/1ps
module dmmao_decim #(
   parameter int CNT_W = 14,
   parameter int ACC_W = 16
) (
   // Clock and control
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic clear_i,
   // Stream and tap count
   input wire logic bit_i,
   input wire logic [4:0] tap_log_i,
   // Result
   output logic signed [ACC_W-1:0] sum_o,
   output logic done_o
);
   logic [CNT_W-1:0] cnt;
   logic signed [ACC_W-1:0] acc;
   logic signed [ACC_W-1:0] step;
   logic [CNT_W-1:0] last;

   assign step = bit_i ? ACC_W'(1) : -ACC_W'(1);
   assign last = CNT_W'((32'h1 << tap_log_i) - 32'h1);

   // One result per N samples gives a first null at the sample rate over N
   always_ff @(posedge clk_i) begin
      if (rst_i || clear_i) begin
         cnt <= '0;
         acc <= '0;
         sum_o <= '0;
         done_o <= 1'b0;
      end else if (ce_i) begin
         done_o <= 1'b0;
         if (cnt == last) begin
            sum_o <= acc + step;
            acc <= '0;
            cnt <= '0;
            done_o <= 1'b1;
         end else begin
            acc <= acc + step;
            cnt <= cnt + CNT_W'(1);
         end
      end
   end
endmodule

// *** rtl/dmmao_core.sv ***
// Result-output stage: two decimators, offset-cycle modes, Wishbone slave
`timescale 1ns/1ps
// How it works
// - Mode 00 shorts input, fine shows negated offset
// - Mode 11 fine result is raw with offset
// - Mode 01 fine result is chopped, offset free
// - Fine rate fs/N, halved in mode 01
// - Mode 00 fast result shows negated offset
// - Mode 11 fast result is raw with offset
// - Mode 01 fast sign-dependent offset formula
// - Fast rate is fast decimator null frequency
// - Fine result 24-bit, point below bit 21
// - 5k/50k models saturate field above 1010
// - 20k model saturates field above 0101
// - 5k model forces bits 5:1 zero
// - Enable bit seven powers converter
// - Setup register holds two-bit offset-cycle select
// - Tap selects give 2048..16384 and 32..256
module dmmao_core
   import dmmao_pkg::*;
#(
   parameter logic [1:0] MODEL = dmmao_pkg::MODEL_50K
) (
   // Clock, reset, enable
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Modulator side
   input wire logic modulator_bit_i,
   output logic converter_on_o,
   output logic [5:0] gain_path_o,
   output logic input_short_o,
   output logic input_swap_o
);
   import dmmao_pkg::*;

   // ----------------------------------------------------------------
   // Registers and decode
   // ----------------------------------------------------------------
   logic [7:0] gain_control_register;
   logic [7:0] converter_setup_register;
   logic [FINE_W-1:0] fine_result;
   logic [FAST_W-1:0] fast_result;
   logic signed [FINE_W-1:0] fine_first;
   logic fine_new;
   logic fast_new;
   dmmao_chop_t chop;
   logic bus_req;
   logic bus_wr;
   logic setup_wr;
   logic fine_rd;
   logic fast_rd;
   logic [1:0] offset_cycle_select;
   logic converter_enable;
   logic conv_clear;
   logic settle;
   logic fine_upd;
   logic fast_upd;

   assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i;
   assign bus_wr = bus_req && wb_we_i && wb_sel_i[0];
   assign setup_wr = bus_wr && (wb_adr_i == OFS_CONVERTER_SETUP);
   assign fine_rd = bus_req && !wb_we_i && (wb_adr_i == OFS_FINE_RESULT);
   assign fast_rd = bus_req && !wb_we_i && (wb_adr_i == OFS_FAST_RESULT);
   assign offset_cycle_select = converter_setup_register[CYS_LSB +: 2];
   assign converter_enable = gain_control_register[CONVERTER_ENABLE_BIT];
   // Any setup change restarts both decimators so fast frames stay aligned
   assign conv_clear = !converter_enable || setup_wr;
   // Routing flops lag one cycle, so the sample taken across a switch is dropped
   assign settle = ce_i && (((offset_cycle_select == CYS_OFFSET_READ) != input_short_o) ||
      (fine_upd && offset_cycle_select == CYS_CANCELLED));

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
      end else if (ce_i) begin
         wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         gain_control_register <= GAIN_CONTROL_RESET;
         converter_setup_register <= CONVERTER_SETUP_RESET;
      end else if (bus_wr) begin
         if (wb_adr_i == OFS_GAIN_CONTROL) begin
            gain_control_register <= wb_dat_i[7:0];
         end
         if (wb_adr_i == OFS_CONVERTER_SETUP) begin
            converter_setup_register <= wb_dat_i[7:0];
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_dat_o <= '0;
      end else if (bus_req) begin
         case (wb_adr_i)
            OFS_GAIN_CONTROL: wb_dat_o <= {24'h000000, gain_control_register};
            OFS_CONVERTER_SETUP: wb_dat_o <= {24'h000000, converter_setup_register};
            OFS_FINE_RESULT: wb_dat_o <= {8'h00, fine_result};
            OFS_FAST_RESULT: wb_dat_o <= {16'h0000, fast_result};
            OFS_STATUS: wb_dat_o <= {30'h0, fast_new, fine_new};
            default: wb_dat_o <= '0;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Decimators
   // ----------------------------------------------------------------
   logic signed [15:0] fine_sum;
   logic signed [9:0] fast_sum;
   logic fine_done;
   logic fast_done;
   logic [4:0] fine_log;
   logic [4:0] fast_log;
   logic signed [FINE_W-1:0] fine_scaled;
   logic signed [FAST_W-1:0] fast_scaled;
   logic signed [FINE_W:0] fine_diff;

   assign fine_log = FINE_LOG_BASE + 5'(converter_setup_register[FINE_TAP_LSB +: 2]);
   assign fast_log = FAST_LOG_BASE + 5'(converter_setup_register[FAST_TAP_LSB +: 2]);

   dmmao_decim #(.CNT_W(14), .ACC_W(16)) fine_decimator (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .clear_i(conv_clear || settle),
      .bit_i(modulator_bit_i),
      .tap_log_i(fine_log),
      .sum_o(fine_sum),
      .done_o(fine_done)
   );

   dmmao_decim #(.CNT_W(8), .ACC_W(10)) fast_decimator (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .clear_i(conv_clear || settle),
      .bit_i(modulator_bit_i),
      .tap_log_i(fast_log),
      .sum_o(fast_sum),
      .done_o(fast_done)
   );

   // Place 1.0 at bit 21 for fine and bit 13 for fast
   assign fine_scaled = FINE_W'(fine_sum) <<<
      (FINE_SHIFT_BASE - 5'(converter_setup_register[FINE_TAP_LSB +: 2]));
   assign fast_scaled = FAST_W'(fast_sum) <<<
      (FAST_SHIFT_BASE - 5'(converter_setup_register[FAST_TAP_LSB +: 2]));
   assign fine_diff = ((FINE_W+1)'(fine_first) - (FINE_W+1)'(fine_scaled)) >>> 1;
   assign fine_upd = fine_done && ce_i && converter_enable;
   assign fast_upd = fast_done && ce_i && converter_enable;

   // Clamp on magnitude, then restore the sign
   function automatic logic [FINE_W-1:0] sat_fine(input logic signed [FINE_W-1:0] v);
      logic [FINE_W-1:0] mag;
      logic [FINE_W-1:0] res;
      logic [3:0] thr;
      mag = v[FINE_W-1] ? FINE_W'(-v) : v;
      thr = (MODEL == MODEL_20K) ? SAT_THR_20K : SAT_THR_WIDE;
      if (mag[21:18] > thr) begin
         mag[21:18] = SAT_FIELD;
      end
      res = v[FINE_W-1] ? FINE_W'(-mag) : mag;
      if (MODEL == MODEL_5K) begin
         res[5:1] = 5'h00;
      end
      return res;
   endfunction

   // ----------------------------------------------------------------
   // Offset-cycle handling
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         input_short_o <= 1'b1;
         converter_on_o <= 1'b0;
         gain_path_o <= '0;
      end else if (ce_i) begin
         input_short_o <= (offset_cycle_select == CYS_OFFSET_READ);
         converter_on_o <= converter_enable;
         gain_path_o <= gain_control_register[5:0];
      end
   end

   // Chop sequencing: a direct frame, then a swapped frame, gives one result
   always_ff @(posedge clk_i) begin
      if (rst_i || (ce_i && conv_clear)) begin
         chop <= CHOP_DIRECT;
         input_swap_o <= 1'b0;
         fine_first <= '0;
      end else if (fine_upd && offset_cycle_select == CYS_CANCELLED) begin
         case (chop)
            CHOP_DIRECT: begin
               fine_first <= fine_scaled;
               chop <= CHOP_SWAPPED;
               input_swap_o <= 1'b1;
            end
            CHOP_SWAPPED: begin
               chop <= CHOP_DIRECT;
               input_swap_o <= 1'b0;
            end
            default: begin
               chop <= CHOP_DIRECT;
               input_swap_o <= 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         fine_result <= '0;
      end else if (fine_upd) begin
         case (offset_cycle_select)
            CYS_OFFSET_READ: fine_result <= sat_fine(-fine_scaled);
            CYS_RAW: fine_result <= sat_fine(fine_scaled);
            CYS_CANCELLED: begin
               if (chop == CHOP_SWAPPED) begin
                  fine_result <= sat_fine(FINE_W'(fine_diff));
               end
            end
            default: fine_result <= fine_result;
         endcase
      end
   end

   // In mode 01 the swapped frames yield offset minus gain times input
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         fast_result <= '0;
      end else if (fast_upd) begin
         case (offset_cycle_select)
            CYS_OFFSET_READ: fast_result <= -fast_scaled;
            CYS_RAW: fast_result <= fast_scaled;
            CYS_CANCELLED: fast_result <= fast_scaled;
            default: fast_result <= fast_result;
         endcase
      end
   end

   // New-result flags: an update in the read cycle keeps the flag set
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         fine_new <= 1'b0;
         fast_new <= 1'b0;
      end else if (ce_i) begin
         if (fine_upd && offset_cycle_select != CYS_RESERVED &&
             !(offset_cycle_select == CYS_CANCELLED && chop == CHOP_DIRECT)) begin
            fine_new <= 1'b1;
         end else if (fine_rd) begin
            fine_new <= 1'b0;
         end
         if (fast_upd && offset_cycle_select != CYS_RESERVED) begin
            fast_new <= 1'b1;
         end else if (fast_rd) begin
            fast_new <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   fine_offset_a: assert property (@(posedge clk_i) disable iff (rst_i)
      fine_upd && offset_cycle_select == CYS_OFFSET_READ |=>
      fine_result == sat_fine(-$past(fine_scaled)))
      else $error("fine offset readout wrong");
   fine_raw_a: assert property (@(posedge clk_i) disable iff (rst_i)
      fine_upd && offset_cycle_select == CYS_RAW |=>
      fine_result == sat_fine($past(fine_scaled)))
      else $error("fine raw result wrong");
   fine_chop_a: assert property (@(posedge clk_i) disable iff (rst_i)
      fine_upd && offset_cycle_select == CYS_CANCELLED && chop == CHOP_SWAPPED |=>
      fine_result == sat_fine(FINE_W'($past(fine_diff))))
      else $error("chopped fine result wrong");
   half_rate_a: assert property (@(posedge clk_i) disable iff (rst_i)
      fine_upd && offset_cycle_select == CYS_CANCELLED && chop == CHOP_DIRECT |=>
      $stable(fine_result) && input_swap_o)
      else $error("fine updated on direct frame");
   fast_offset_a: assert property (@(posedge clk_i) disable iff (rst_i)
      fast_upd && offset_cycle_select == CYS_OFFSET_READ |=>
      fast_result == -$past(fast_scaled) && input_short_o)
      else $error("fast offset readout wrong");
   fast_raw_a: assert property (@(posedge clk_i) disable iff (rst_i)
      fast_upd && offset_cycle_select == CYS_RAW |=> fast_result == $past(fast_scaled))
      else $error("fast raw result wrong");
   low_bits_a: assert property (@(posedge clk_i) disable iff (rst_i)
      MODEL == MODEL_5K |-> fine_result[5:1] == 5'h00)
      else $error("low fine bits not zero");
   sat_field_a: assert property (@(posedge clk_i) disable iff (rst_i)
      fine_upd && !fine_scaled[FINE_W-1] &&
      fine_scaled[21:18] > ((MODEL == MODEL_20K) ? SAT_THR_20K : SAT_THR_WIDE) &&
      offset_cycle_select == CYS_RAW |=>
      fine_result[21:18] == SAT_FIELD)
      else $error("fine field not saturated");
   off_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
      !converter_enable ##1 !converter_enable |-> $stable(fine_result) && $stable(fast_result))
      else $error("result moved while converter off");
   reserved_a: assert property (@(posedge clk_i) disable iff (rst_i)
      offset_cycle_select == CYS_RESERVED |=> $stable(fine_result))
      else $error("result moved in reserved mode");
endmodule

// *** tb/dmmao_modulator.sv ***
// Front-end and one-bit modulator model facing the result-output stage
`timescale 1ns/1ps
module dmmao_modulator #(
   parameter int OFFSET = 4
) (
   // Clock and sample enable
   input wire logic clk_i,
   input wire logic ce_i,
   // Input level in 1/32 of full scale, even values only
   input wire logic signed [7:0] level_i,
   // Input routing from the device
   input wire logic short_i,
   input wire logic swap_i,
   // Bit stream
   output logic bit_o
);
   // ----------------------------------------------------------------
   // Periodic pattern: any 32 taken samples sum exactly to OFFSET plus the routed level
   // ----------------------------------------------------------------
   int ph = 0;
   int k;

   always @(posedge clk_i) begin
      if (ce_i) begin
         ph <= (ph + 1) % 32;
      end
   end

   always_comb begin
      if (short_i) begin
         k = OFFSET;
      end else if (swap_i) begin
         k = OFFSET - level_i;
      end else begin
         k = OFFSET + level_i;
      end
      bit_o = (ph < (k + 32) / 2);
   end
endmodule

// *** tb/tb_top.sv ***
// Self-checking bench for the converter result-output stage
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
   $display("wrong value %s expected %h seen %h", nm, e, g); end end
module tb_top;
   import dmmao_pkg::*;
   localparam int OFS_K = 4;
   logic clk_i = 0, rst_i = 1, ce_i = 1, stall = 0;
   logic wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
   logic wb_ack_o, mod_bit, conv_on, in_short, in_swap;
   logic [5:0] gain_path;
   logic signed [7:0] level = 8'sh00;
   int mismatches = 0, n_checks = 0, cyc_cnt = 0;

   always #2.5 clk_i = ~clk_i;
   always @(posedge clk_i) cyc_cnt <= cyc_cnt + 1;
   // Stalls only where no timing is measured
   always @(posedge clk_i) ce_i <= stall ? ($urandom_range(3) != 0) : 1'b1;

   dmmao_core #(.MODEL(MODEL_20K)) uut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
      .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .modulator_bit_i(mod_bit), .converter_on_o(conv_on), .gain_path_o(gain_path),
      .input_short_o(in_short), .input_swap_o(in_swap));
   dmmao_modulator #(.OFFSET(OFS_K)) fe (.clk_i(clk_i), .ce_i(ce_i), .level_i(level),
      .short_i(in_short), .swap_i(in_swap), .bit_o(mod_bit));

   // ----------------------------------------------------------------
   // Expected values
   // ----------------------------------------------------------------
   function automatic logic [31:0] fine_exp(input int k);
      logic [23:0] a;
      a = 24'((k < 0 ? -k : k) << 16);
      if (a[21:18] > SAT_THR_20K) a[21:18] = SAT_FIELD;
      return {8'h00, (k < 0) ? -a : a};
   endfunction

   function automatic logic [31:0] fast_exp(input int k);
      return {16'h0000, 16'(k * 256)};
   endfunction

   // ----------------------------------------------------------------
   // Bus and measurement tasks
   // ----------------------------------------------------------------
   task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d,
         output logic [31:0] q);
      int n;
      n = 0;
      // A frozen ack from a stalled cycle must not answer the next request
      while (wb_ack_o === 1'b1) @(posedge clk_i);
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_sel_i <= 4'hf;
      wb_dat_i <= d;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 1000);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      if (n >= 1000) mismatches++;
   endtask

   task automatic run_mode(input logic [1:0] mode, input logic [1:0] ftap,
         input logic [1:0] stap, input int b, output int dt, output logic [31:0] fine,
         output logic [31:0] fast);
      logic [31:0] q;
      int t0, n;
      n = 0;
      bus(1'b1, OFS_CONVERTER_SETUP, {26'h0, mode, stap, ftap}, q);
      t0 = cyc_cnt;
      bus(1'b0, OFS_FINE_RESULT, 32'h0, q);
      bus(1'b0, OFS_FAST_RESULT, 32'h0, q);
      do begin
         bus(1'b0, OFS_STATUS, 32'h0, q);
         n++;
      end while (q[b] !== 1'b1 && n < 12000);
      dt = cyc_cnt - t0;
      bus(1'b0, OFS_FINE_RESULT, 32'h0, fine);
      bus(1'b0, OFS_FAST_RESULT, 32'h0, fast);
      if (n >= 12000) mismatches++;
   endtask

   task automatic close_out;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   initial begin
      repeat (95000) @(posedge clk_i);
      mismatches++;
      close_out;
   end

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      logic [31:0] q, fine, fast, off;
      logic [5:0] g;
      int dt, x;
      void'($urandom(26513));
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      bus(1'b0, OFS_GAIN_CONTROL, 32'h0, q);
      `CHK("gain reset", 32'h0, q)
      bus(1'b0, OFS_CONVERTER_SETUP, 32'h0, q);
      `CHK("setup reset", 32'h0, q)
      bus(1'b0, 8'h14, 32'h0, q);
      `CHK("unmapped", 32'h0, q)
      `CHK("short at reset", 1'b1, in_short)
      g = 6'($urandom);
      bus(1'b1, OFS_GAIN_CONTROL, {24'h0, 2'b10, g}, q);
      bus(1'b0, OFS_GAIN_CONTROL, 32'h0, q);
      `CHK("gain readback", {24'h0, 2'b10, g}, q)
      `CHK("converter on", 1'b1, conv_on)
      `CHK("gain path", g, gain_path)
      run_mode(CYS_OFFSET_READ, 2'h0, 2'h0, STAT_FINE_NEW_BIT, dt, fine, off);
      `CHK("short", 1'b1, in_short)
      `CHK("offset fine", fine_exp(-OFS_K), fine)
      `CHK("offset fast", fast_exp(-OFS_K), off)
      level <= 8'sh06;
      for (int t = 0; t < 4; t++) begin
         run_mode(CYS_RAW, 2'(t), 2'h0, STAT_FINE_NEW_BIT, dt, fine, fast);
         `CHK("fine rate", 1'b1, dt >= (2048 << t) && dt <= (2048 << t) + 12)
         `CHK("tap fine", fine_exp(6 + OFS_K), fine)
      end
      for (int i = 0; i < 4; i++) begin
         x = (i == 0) ? 28 : (i == 1) ? -28 : 2 * $urandom_range(28) - 28;
         level <= 8'(x);
         stall <= (i > 0);
         run_mode(CYS_RAW, 2'h0, 2'h0, STAT_FINE_NEW_BIT, dt, fine, fast);
         `CHK("raw fine", fine_exp(x + OFS_K), fine)
         `CHK("raw fast", fast_exp(x + OFS_K), fast)
         `CHK("bar graph", fast_exp(x), {16'h0, fast[15:0] + off[15:0]})
         run_mode(CYS_CANCELLED, 2'h0, 2'h0, STAT_FINE_NEW_BIT, dt, fine, fast);
         if (i == 0) `CHK("cancelled rate", 1'b1, dt >= 4096 && dt <= 4108)
         `CHK("cancelled fine", fine_exp(x), fine)
         `CHK("chop fast", 1'b1, fast === fast_exp(x + OFS_K) || fast === fast_exp(OFS_K - x))
      end
      stall <= 1'b0;
      for (int s = 0; s < 4; s++) begin
         run_mode(CYS_RAW, 2'h0, 2'(s), STAT_FAST_NEW_BIT, dt, fine, fast);
         `CHK("fast rate", 1'b1, dt >= (32 << s) && dt <= (32 << s) + 12)
      end
      bus(1'b1, OFS_CONVERTER_SETUP, {26'h0, CYS_RESERVED, 4'h0}, q);
      bus(1'b0, OFS_FINE_RESULT, 32'h0, fine);
      bus(1'b0, OFS_FAST_RESULT, 32'h0, q);
      repeat (2200) @(posedge clk_i);
      bus(1'b0, OFS_STATUS, 32'h0, q);
      `CHK("reserved flags", 32'h0, q)
      bus(1'b0, OFS_FINE_RESULT, 32'h0, q);
      `CHK("reserved held", fine, q)
      bus(1'b1, OFS_GAIN_CONTROL, 32'h0, q);
      bus(1'b1, OFS_CONVERTER_SETUP, {26'h0, CYS_RAW, 4'h0}, q);
      `CHK("converter off", 1'b0, conv_on)
      bus(1'b0, OFS_FINE_RESULT, 32'h0, q);
      repeat (2200) @(posedge clk_i);
      bus(1'b0, OFS_STATUS, 32'h0, q);
      `CHK("off no result", 1'b0, q[STAT_FINE_NEW_BIT])
      close_out;
   end
endmodule
